/* tb_vga_panel_input_timing.sv */
// self-checking bench: controller and panel joined over the link
`timescale 1ns/100ps
`default_nettype none

module tb_vga_panel_input_timing;
  // ****
  // stimulus, model and checks
  // ****
  logic        clock      = 1'b0;          // own clock
  logic        rstn       = 1'b0;          // reset, low
  logic        in_valid   = 1'b0;          // push offer
  logic [17:0] in_rgb     = 18'h0_0000;    // pushed pixel
  logic        scan_h_sel = 1'b0;          // horizontal select
  logic        scan_v_sel = 1'b0;          // vertical select
  logic [31:0] lf         = 32'h0000_005A; // random state
  wire         in_ready, underrun, pixel_valid, frame_start; // design flags
  wire  [9:0]  pixel_x;                    // column out
  wire  [8:0]  pixel_y;                    // row out
  wire  [17:0] pixel_rgb;                  // colour out
  logic [17:0] exp_q[$];                   // model: pixels in display order
  int          num_errors = 0, num_checks = 0, k = 0, nun = 0, nfs = 0, cyc = 0;

  vpt_link_if link_bus ();
  vpt_controller i_vpt_controller (.link(link_bus), .clock, .rstn, .in_valid, .in_ready,
    .in_rgb, .use_strobe(1'b1), .scan_h_sel, .scan_v_sel, .underrun);
  vpt_panel i_vpt_panel (.link(link_bus), .clock, .rstn, .pixel_valid, .pixel_x, .pixel_y,
    .pixel_rgb, .frame_start);
  vpt_link_assertions i_chk (.clock, .rstn, .pixel_sample_clock(link_bus.pixel_sample_clock),
    .line_sync_n(link_bus.line_sync_n), .frame_sync_n(link_bus.frame_sync_n),
    .horizontal_data_valid_strobe(link_bus.horizontal_data_valid_strobe),
    .red_level_bits(link_bus.red_level_bits), .green_level_bits(link_bus.green_level_bits),
    .blue_level_bits(link_bus.blue_level_bits));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic ok, input string what);
    num_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("ERROR %0t %s", $time, what);
    end
  endtask

  // pixels fill the first visible row, then the next, mirrored by the selects
  task automatic check_pixel;
    logic [17:0] e;
    e = 'x;
    if (exp_q.size() > 0) e = exp_q.pop_front();
    chk(pixel_rgb === e, "pixel colour");
    chk(pixel_x === (scan_h_sel ? 10'(k % 640) : 10'(639 - k % 640)), "column");
    chk(pixel_y === (scan_v_sel ? 9'(k / 640) : 9'(479 - k / 640)), "row");
    k++;
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial forever #50 clock = ~clock;

  // pushes run flat out; a gap mid-row drains the buffer to two black pixels
  always @(posedge clock) begin
    if (rstn) begin
      cyc++;
      if (cyc == 30) chk(!in_ready && exp_q.size() == 16, "buffer not full");
      if (in_valid && in_ready) exp_q.push_back(in_rgb);
      if (underrun === 1'b1) begin
        exp_q.push_back(18'h0_0000);
        nun++;
      end
      if (frame_start === 1'b1) nfs++;
      if (pixel_valid === 1'b1) check_pixel();
      lf = lfsr(lf);
      in_rgb <= lf[17:0];
      in_valid <= !(k >= 100 && nun < 2);
    end
  end

  initial begin
    scan_h_sel = lf[0];
    scan_v_sel = lf[1];
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    while (k < 1280 && cyc < 120000) @(posedge clock);
    chk(k >= 1280, "timeout");
    chk(nfs == 1 && nun == 2, "frame or underrun count");
    chk(link_bus.scan_h_sel === scan_h_sel && link_bus.scan_v_sel === scan_v_sel, "selects");
    report_and_stop();
  end
endmodule

`default_nettype wire

/* vpt_controller.sv */
// display controller end: pixel buffer and timing generator
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// pixel buffer
// ****************************************************************
// depth must be a power of two, pointers wrap freely
module vpt_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,     // own clock
  input  wire logic             rstn,      // async reset, low
  input  wire logic             in_valid,  // word offered
  output var  logic             in_ready,  // room for a word
  input  wire logic [WIDTH-1:0] in_data,   // word in
  output var  logic             out_valid, // word available
  input  wire logic             out_ready, // word taken
  output var  logic [WIDTH-1:0] out_data   // word out
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;      // storage
    logic [AW-1:0]               wr_ptr;   // write slot
    logic [AW-1:0]               rd_ptr;   // read slot
    logic [AW:0]                 count;    // words held
    logic                        in_ready; // not full
    logic                        out_valid;// not empty
  } vpt_fifo_t;

  localparam vpt_fifo_t FIFO_RESET = '{in_ready: 1'b1, default: '0};

  vpt_fifo_t s_reg;   // state
  vpt_fifo_t s_next;  // next state
  logic      push;    // write this cycle
  logic      pop;     // read this cycle

  assign push      = in_valid && s_reg.in_ready;
  assign pop       = out_ready && s_reg.out_valid;
  assign in_ready  = s_reg.in_ready;
  assign out_valid = s_reg.out_valid;
  assign out_data  = s_reg.mem[s_reg.rd_ptr];

  // pointer and flag update; flags registered so ports come from flops
  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wr_ptr] = in_data;
      s_next.wr_ptr = s_reg.wr_ptr + AW'(1);
    end
    if (pop) begin
      s_next.rd_ptr = s_reg.rd_ptr + AW'(1);
    end
    s_next.count     = s_reg.count + (AW + 1)'(push) - (AW + 1)'(pop);
    s_next.in_ready  = s_next.count != (AW + 1)'(DEPTH);
    s_next.out_valid = s_next.count != '0;
  end

  // state register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_reg <= FIFO_RESET;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

// ****************************************************************
// timing generator
// ****************************************************************
module vpt_controller (
  vpt_link_if.ctrl                        link,        // pins to the panel
  input  wire logic                       clock,       // own clock, 10 MHz
  input  wire logic                       rstn,        // async reset, low
  input  wire logic                       in_valid,    // pixel offered
  output var  logic                       in_ready,    // buffer has room
  input  wire logic [vpt_pkg::RGB_W-1:0]  in_rgb,      // pixel red,green,blue
  input  wire logic                       use_strobe,  // place lines by strobe
  input  wire logic                       scan_h_sel,  // horizontal direction
  input  wire logic                       scan_v_sel,  // vertical direction
  output var  logic                       underrun     // pixel sent from empty buffer
);
  vpt_pkg::vpt_ctl_t          s_reg;      // state
  vpt_pkg::vpt_ctl_t          s_next;     // next state
  logic                       advance;    // pixel clock falls now
  logic [9:0]                 h_adv;      // clock count after advance
  logic [9:0]                 l_adv;      // line count after advance
  logic [9:0]                 first_px;   // first data clock of a line
  logic                       line_vis;   // visible line
  logic                       pix_on;     // data clock
  logic                       data_win;   // data window of any line
  logic                       fifo_valid; // buffer not empty
  logic [vpt_pkg::RGB_W-1:0]  fifo_data;  // buffer head

  // ****************************************************************
  // buffer in the data path
  // ****************************************************************
  vpt_fifo #(
    .WIDTH (vpt_pkg::RGB_W),
    .DEPTH (vpt_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rstn      (rstn),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   (in_rgb),
    .out_valid (fifo_valid),
    .out_ready (advance && pix_on),
    .out_data  (fifo_data)
  );

  // ****************************************************************
  // counters
  // ****************************************************************
  // all but the selects change on the falling pixel clock, so they are steady at the rise
  assign advance = (s_reg.div == vpt_pkg::PIX_HALF_LAST) && s_reg.pclk;

  // fixed 800 clock line within 770..900
  assign h_adv = (s_reg.hcount == vpt_pkg::LINE_PERIOD - 10'h001) ? 10'h000
               : s_reg.hcount + 10'h001;

  // fixed 525 line frame within 515..560
  assign l_adv = (s_reg.hcount != vpt_pkg::LINE_PERIOD - 10'h001) ? s_reg.lcount
               : (s_reg.lcount == vpt_pkg::FRAME_PERIOD - 10'h001) ? 10'h000
               : s_reg.lcount + 10'h001;

  // strobe at clock 120 lies inside 44..136 and past clock 100
  assign first_px = use_strobe ? vpt_pkg::STROBE_START
                  : vpt_pkg::DEFAULT_FIRST_PIXEL;

  // lines 34..513 carry the picture, matching the panel's fixed start
  assign line_vis = (l_adv >= vpt_pkg::FIRST_VISIBLE_LINE)
                 && (l_adv < vpt_pkg::FIRST_VISIBLE_LINE + vpt_pkg::ACTIVE_LINES);

  // same window on every line, blank ones too, so the panel has already
  // switched to strobe placement when the first visible line arrives
  assign data_win = (h_adv >= first_px)
                 && (h_adv < first_px + vpt_pkg::ACTIVE_PIXELS);

  // exactly 640 data clocks on each visible line
  assign pix_on = line_vis && data_win;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_next = s_reg;
    s_next.underrun = 1'b0;
    // selects follow the user inputs; meant to be static
    s_next.hdir = scan_h_sel;
    s_next.vdir = scan_v_sel;
    // clock divider, the pin toggles every half period
    if (s_reg.div == vpt_pkg::PIX_HALF_LAST) begin
      s_next.div  = 2'h0;
      s_next.pclk = ~s_reg.pclk;
    end else begin
      s_next.div = s_reg.div + 2'h1;
    end
    // one pixel step on each falling edge
    if (advance) begin
      s_next.hcount = h_adv;
      s_next.lcount = l_adv;
      // both syncs change on the same step, zero skew
      s_next.line_sync_n  = !(h_adv < vpt_pkg::LINE_SYNC_WIDTH);
      s_next.frame_sync_n = !(l_adv < vpt_pkg::FRAME_SYNC_WIDTH);
      // strobe pulses on every line, never stuck high
      s_next.strobe = use_strobe && data_win;
      if (pix_on) begin
        // an empty buffer sends black rather than stalling the raster
        s_next.rgb      = fifo_valid ? fifo_data : '0;
        s_next.underrun = !fifo_valid;
      end else begin
        s_next.rgb = '0;
      end
    end
  end

  // state register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_reg <= vpt_pkg::CTL_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // pins, all straight from flops
  // ****************************************************************
  assign link.pixel_sample_clock           = s_reg.pclk;
  assign link.line_sync_n                  = s_reg.line_sync_n;
  assign link.frame_sync_n                 = s_reg.frame_sync_n;
  assign link.horizontal_data_valid_strobe = s_reg.strobe;
  assign link.red_level_bits               = s_reg.rgb[17:12];
  assign link.green_level_bits             = s_reg.rgb[11:6];
  assign link.blue_level_bits              = s_reg.rgb[5:0];
  assign link.scan_h_sel                   = s_reg.hdir;
  assign link.scan_v_sel                   = s_reg.vdir;
  assign underrun                          = s_reg.underrun;
endmodule

`default_nettype wire

/* vpt_link_assertions.sv */
// timing checker for the controller to panel link
`timescale 1ns/100ps
`default_nettype none

module vpt_link_assertions (
  input wire logic       clock,                        // own clock
  input wire logic       rstn,                         // reset, low
  input wire logic       pixel_sample_clock,           // pixel clock
  input wire logic       line_sync_n,                  // line sync
  input wire logic       frame_sync_n,                 // frame sync
  input wire logic       horizontal_data_valid_strobe, // data valid
  input wire logic [5:0] red_level_bits,               // red
  input wire logic [5:0] green_level_bits,             // green
  input wire logic [5:0] blue_level_bits               // blue
);
  // ****
  // link state seen at each pixel clock rise
  // ****
  logic       pclk_reg;                                   // clock last cycle
  logic       hs_reg;                                     // line sync at last rise
  logic       fs_reg;                                     // frame sync at last rise
  logic       stb_reg;                                    // strobe at last rise
  logic [9:0] hcnt_reg;                                   // clock index in line
  logic [9:0] lcnt_reg;                                   // line index in frame
  wire        rise = pixel_sample_clock & ~pclk_reg;      // pixel clock rose
  wire        nl   = rise & hs_reg & ~line_sync_n;        // line starts
  wire        ff   = rise & fs_reg & ~frame_sync_n;       // frame starts
  wire        stb  = horizontal_data_valid_strobe;        // short alias

  // counts reset to a last index, so the first line and frame pass
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pclk_reg <= 1'b0;
      hs_reg   <= 1'b1;
      fs_reg   <= 1'b1;
      stb_reg  <= 1'b0;
      hcnt_reg <= 10'h31F;
      lcnt_reg <= 10'h20C;
    end else begin
      pclk_reg <= pixel_sample_clock;
      if (rise) begin
        hs_reg   <= line_sync_n;
        fs_reg   <= frame_sync_n;
        stb_reg  <= stb;
        hcnt_reg <= nl ? 10'h000 : hcnt_reg + 10'h001;
        lcnt_reg <= ff ? 10'h000 : (nl ? lcnt_reg + 10'h001 : lcnt_reg);
      end
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  clk_half_a: assert property ($rose(pixel_sample_clock) |=> pixel_sample_clock ##1
    !pixel_sample_clock) else $error("pixel clock half period wrong");
  hs_width_a: assert property (rise & ~hs_reg & line_sync_n |-> hcnt_reg inside {[1:199]})
    else $error("line sync width out of range");
  line_len_a: assert property (nl |-> hcnt_reg inside {[769:899]})
    else $error("line period out of range");
  frame_len_a: assert property (ff |-> lcnt_reg inside {[514:559]})
    else $error("frame period out of range");
  frame_width_a: assert property (rise & ~fs_reg & frame_sync_n |-> lcnt_reg <= 10'h021)
    else $error("frame sync too long");
  sync_align_a: assert property (rise & (fs_reg != frame_sync_n) |->
    hcnt_reg >= 10'h31D || hcnt_reg <= 10'h001) else $error("frame sync edge off line");
  stb_window_a: assert property (rise & ~stb_reg & stb |-> hcnt_reg inside {[43:135]})
    else $error("strobe rises outside window");
  stb_release_a: assert property (rise & stb |-> !nl && hcnt_reg <= 10'h306)
    else $error("strobe held too long");
  data_hold_a: assert property (pixel_sample_clock && $past(pixel_sample_clock) |->
    $stable({red_level_bits, green_level_bits, blue_level_bits})) else $error("colour moved");

  line_seen_c: cover property (nl);
  frame_seen_c: cover property (ff);
  strobe_seen_c: cover property (rise & ~stb_reg & stb);
endmodule

`default_nettype wire

/* vpt_link_if.sv */
// pin bundle between display controller and panel
`timescale 1ns/100ps
`default_nettype none

interface vpt_link_if;
  logic                             pixel_sample_clock;           // pixel clock
  logic                             line_sync_n;                  // line sync, low
  logic                             frame_sync_n;                 // frame sync, low
  logic                             horizontal_data_valid_strobe; // data valid
  logic [vpt_pkg::LEVEL_W-1:0]      red_level_bits;               // red level
  logic [vpt_pkg::LEVEL_W-1:0]      green_level_bits;             // green level
  logic [vpt_pkg::LEVEL_W-1:0]      blue_level_bits;              // blue level
  logic                             scan_h_sel;                   // horizontal scan select
  logic                             scan_v_sel;                   // vertical scan select

  modport ctrl (
    output pixel_sample_clock, line_sync_n, frame_sync_n, horizontal_data_valid_strobe,
    output red_level_bits, green_level_bits, blue_level_bits, scan_h_sel, scan_v_sel
  );

  modport panel (
    input pixel_sample_clock, line_sync_n, frame_sync_n, horizontal_data_valid_strobe,
    input red_level_bits, green_level_bits, blue_level_bits, scan_h_sel, scan_v_sel
  );
endinterface

`default_nettype wire

/* vpt_panel.sv */
// panel end: samples the link and places pixels on the screen
`timescale 1ns/100ps
`default_nettype none

module vpt_panel (
  vpt_link_if.panel                      link,        // pins from the controller
  input  wire logic                      clock,       // own clock, 10 MHz
  input  wire logic                      rstn,        // async reset, low
  output var  logic                      pixel_valid, // pixel placed, pulse
  output var  logic [9:0]                pixel_x,     // screen column
  output var  logic [8:0]                pixel_y,     // screen row
  output var  logic [vpt_pkg::RGB_W-1:0] pixel_rgb,   // pixel colour
  output var  logic                      frame_start  // frame sync seen, pulse
);
  vpt_pkg::vpt_pnl_t          s_reg;    // state
  vpt_pkg::vpt_pnl_t          s_next;   // next state
  logic [vpt_pkg::LINK_W-1:0] smp;      // synchronised link
  logic                       rise;     // pixel clock rose
  logic                       stb_rise; // strobe rose at this sample
  logic                       line_vis; // visible line

  // only the second stage is ever looked at
  assign smp      = s_reg.s2;
  assign rise     = smp[vpt_pkg::LNK_CLK] && !s_reg.pclk_prev;
  assign stb_rise = smp[vpt_pkg::LNK_STB] && !s_reg.strobe_prev;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [9:0] hn;  // clock count of this sample
    logic [9:0] ly;  // visible line index
    hn       = s_reg.hcount;
    ly       = 10'h000;
    line_vis = 1'b0;
    s_next   = s_reg;
    // two stage synchroniser on every pin
    s_next.s1 = {link.pixel_sample_clock, link.line_sync_n, link.frame_sync_n,
                 link.horizontal_data_valid_strobe, link.scan_h_sel, link.scan_v_sel,
                 link.red_level_bits, link.green_level_bits, link.blue_level_bits};
    s_next.s2          = s_reg.s1;
    s_next.pclk_prev   = smp[vpt_pkg::LNK_CLK];
    s_next.pixel_valid = 1'b0;
    s_next.frame_start = 1'b0;
    // all pin values but the clock are taken only at a pixel clock rise
    if (rise) begin
      s_next.hs_prev     = smp[vpt_pkg::LNK_HS];
      s_next.vs_prev     = smp[vpt_pkg::LNK_VS];
      s_next.strobe_prev = smp[vpt_pkg::LNK_STB];
      if (!smp[vpt_pkg::LNK_HS] && s_reg.hs_prev) begin
        // falling line sync restarts the line
        hn                 = 10'h000;
        s_next.strobe_mode = s_reg.strobe_seen;
        s_next.strobe_seen = 1'b0;
        s_next.phase       = vpt_pkg::VPT_PH_WAIT;
        s_next.early       = 1'b0;
        if (!smp[vpt_pkg::LNK_VS] && s_reg.vs_prev) begin
          s_next.lcount      = 10'h000;
          s_next.frame_start = 1'b1;
        end else if (s_reg.lcount != vpt_pkg::COUNT_IDLE) begin
          s_next.lcount = s_reg.lcount + 10'h001;
        end
      end else if (hn != vpt_pkg::COUNT_IDLE) begin
        hn = hn + 10'h001;  // saturates on a stuck link
      end
      s_next.hcount = hn;
      if (smp[vpt_pkg::LNK_STB]) begin
        s_next.strobe_seen = 1'b1;
      end
      // horizontal start selection
      case (s_next.phase)
        vpt_pkg::VPT_PH_WAIT: begin
          if (stb_rise) begin
            // strobe rise marks the first pixel
            s_next.phase  = vpt_pkg::VPT_PH_ACTIVE;
            s_next.xcount = 10'h000;
            s_next.early  = hn < vpt_pkg::DEFAULT_FIRST_PIXEL;
          end else if (!s_next.strobe_mode && hn == vpt_pkg::DEFAULT_FIRST_PIXEL) begin
            // no strobe last line: default start position
            s_next.phase  = vpt_pkg::VPT_PH_ACTIVE;
            s_next.xcount = 10'h000;
          end
        end
        vpt_pkg::VPT_PH_ACTIVE: begin
          if (s_reg.early && hn == vpt_pkg::DEFAULT_FIRST_PIXEL) begin
            // early strobe gone before clock 100: fall back to default
            if (!smp[vpt_pkg::LNK_STB]) begin
              s_next.xcount = 10'h000;
            end
            s_next.early = 1'b0;
          end
        end
        vpt_pkg::VPT_PH_DONE: begin
        end
        default: begin
          s_next.phase = vpt_pkg::VPT_PH_DONE;
        end
      endcase
      // vertical place depends only on the line count and the vertical select, never the strobe
      line_vis = (s_next.lcount >= vpt_pkg::FIRST_VISIBLE_LINE)
              && (s_next.lcount < vpt_pkg::FIRST_VISIBLE_LINE
                                  + vpt_pkg::ACTIVE_LINES);
      ly = s_next.lcount - vpt_pkg::FIRST_VISIBLE_LINE;
      if (s_next.phase == vpt_pkg::VPT_PH_ACTIVE) begin
        if (line_vis) begin
          s_next.pixel_valid = 1'b1;
          s_next.pixel_rgb   = smp[vpt_pkg::RGB_W-1:0];
          // select low mirrors the image
          s_next.pixel_x = smp[vpt_pkg::LNK_HDIR] ? s_next.xcount
                         : vpt_pkg::ACTIVE_PIXELS - 10'h001 - s_next.xcount;
          s_next.pixel_y = smp[vpt_pkg::LNK_VDIR] ? ly[8:0]
                         : 9'(vpt_pkg::ACTIVE_LINES - 10'h001 - ly);
        end
        if (s_next.xcount == vpt_pkg::ACTIVE_PIXELS - 10'h001) begin
          s_next.phase = vpt_pkg::VPT_PH_DONE;
        end
        s_next.xcount = s_next.xcount + 10'h001;
      end
    end
  end

  // state register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_reg <= vpt_pkg::PNL_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // outputs, straight from flops
  // ****************************************************************
  assign pixel_valid = s_reg.pixel_valid;
  assign pixel_x     = s_reg.pixel_x;
  assign pixel_y     = s_reg.pixel_y;
  assign pixel_rgb   = s_reg.pixel_rgb;
  assign frame_start = s_reg.frame_start;
endmodule

`default_nettype wire

/* vpt_pkg.sv */
// shared constants, state types and reset values for the panel timing link
package vpt_pkg;

  // ****************************************************************
  // clock rates and divider
  // ****************************************************************
  localparam int SYS_PERIOD_NS     = 100;    // own clock period
  localparam int PIX_NOM_KHZ       = 25200;  // nominal pixel clock
  localparam int PIX_MAX_KHZ       = 27800;  // fastest pixel clock allowed
  localparam int PIX_MIN_PERIOD_NS = (1000000 + PIX_MAX_KHZ - 1) / PIX_MAX_KHZ;
  localparam int PIX_HALF_RATE     = (PIX_MIN_PERIOD_NS + 2 * SYS_PERIOD_NS - 1)
                                     / (2 * SYS_PERIOD_NS);
  // the receiver samples the clock through two flops, so keep two cycles a half
  localparam int PIX_HALF_SYNC     = 2;
  localparam int PIX_HALF_CYCLES   = (PIX_HALF_RATE > PIX_HALF_SYNC) ? PIX_HALF_RATE
                                                                     : PIX_HALF_SYNC;
  localparam logic [1:0] PIX_HALF_LAST = 2'(PIX_HALF_CYCLES - 1);

  // ****************************************************************
  // line and frame timing, in pixel clocks and lines
  // ****************************************************************
  localparam logic [9:0] LINE_PERIOD         = 10'h320;  // 800 clocks
  localparam logic [9:0] LINE_SYNC_WIDTH     = 10'h060;  // 96 clocks
  localparam logic [9:0] FRAME_PERIOD        = 10'h20D;  // 525 lines
  localparam logic [9:0] FRAME_SYNC_WIDTH    = 10'h002;  // 2 lines
  localparam logic [9:0] ACTIVE_PIXELS       = 10'h280;  // 640 clocks
  localparam logic [9:0] ACTIVE_LINES        = 10'h1E0;  // 480 lines
  localparam logic [9:0] DEFAULT_FIRST_PIXEL = 10'h064;  // clock 100
  localparam logic [9:0] STROBE_START        = 10'h078;  // clock 120
  localparam logic [9:0] STROBE_EARLIEST     = 10'h02C;  // clock 44
  localparam logic [9:0] STROBE_LATEST_SLACK = 10'h298;  // 664 clocks
  localparam logic [9:0] FIRST_VISIBLE_LINE  = 10'h022;  // line 34
  localparam logic [9:0] COUNT_IDLE          = 10'h3FF;  // saturated count

  // ****************************************************************
  // data widths and buffer
  // ****************************************************************
  localparam int LEVEL_W    = 6;
  localparam int RGB_W      = 18;
  localparam int FIFO_DEPTH = 16;

  // ****************************************************************
  // bit positions of the sampled link vector
  // ****************************************************************
  localparam int LINK_W    = 24;
  localparam int LNK_CLK   = 23;
  localparam int LNK_HS    = 22;
  localparam int LNK_VS    = 21;
  localparam int LNK_STB   = 20;
  localparam int LNK_HDIR  = 19;
  localparam int LNK_VDIR  = 18;

  // ****************************************************************
  // state types
  // ****************************************************************
  typedef enum logic [1:0] {
    VPT_PH_WAIT   = 2'b00,  // waiting for the first pixel
    VPT_PH_ACTIVE = 2'b01,  // taking pixels
    VPT_PH_DONE   = 2'b10   // line filled
  } vpt_phase_t;

  typedef struct packed {
    logic [1:0]       div;          // divider count
    logic             pclk;         // pixel clock out
    logic [9:0]       hcount;       // clock within line
    logic [9:0]       lcount;       // line within frame
    logic             line_sync_n;  // line sync out
    logic             frame_sync_n; // frame sync out
    logic             strobe;       // data valid strobe out
    logic [RGB_W-1:0] rgb;          // colour out
    logic             hdir;         // horizontal select out
    logic             vdir;         // vertical select out
    logic             underrun;     // empty buffer pulse
  } vpt_ctl_t;

  typedef struct packed {
    logic [LINK_W-1:0] s1;          // first sync stage
    logic [LINK_W-1:0] s2;          // second sync stage
    logic              pclk_prev;   // clock edge finder
    logic              hs_prev;     // line sync at last sample
    logic              vs_prev;     // frame sync at last sample
    logic              strobe_prev; // strobe at last sample
    logic [9:0]        hcount;      // clocks since line sync
    logic [9:0]        lcount;      // lines since frame sync
    logic              strobe_seen; // strobe high this line
    logic              strobe_mode; // strobe high last line
    vpt_phase_t        phase;       // line phase
    logic              early;       // strobe rose before clock 100
    logic [9:0]        xcount;      // pixel within line
    logic              pixel_valid; // pixel out pulse
    logic [9:0]        pixel_x;     // column out
    logic [8:0]        pixel_y;     // row out
    logic [RGB_W-1:0]  pixel_rgb;   // colour out
    logic              frame_start; // frame sync seen pulse
  } vpt_pnl_t;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam vpt_ctl_t CTL_RESET = '{line_sync_n: 1'b1, frame_sync_n: 1'b1, default: '0};
  localparam vpt_pnl_t PNL_RESET = '{hs_prev: 1'b1, vs_prev: 1'b1, hcount: COUNT_IDLE,
                                     lcount: COUNT_IDLE, phase: VPT_PH_DONE, default: '0};

endpackage
